// *** include/cbc_defines.svh ***
// address map, field positions and timing constants of the cell balance block
`ifndef CBC_DEFINES_SVH
`define CBC_DEFINES_SVH

// register indexes; byte address is four times the index
`define CBC_IDX_SETUP 6'h13
`define CBC_IDX_PATTERN 6'h14
`define CBC_IDX_DURATION 6'h20
`define CBC_IDX_COMMAND 6'h21
`define CBC_IDX_IRQ_STATUS 6'h22
`define CBC_IDX_IRQ_MASK 6'h23
`define CBC_IDX_STATE 6'h24

// setup register fields
`define CBC_SETUP_MODE_LSB 0
`define CBC_SETUP_MODE_MSB 1
`define CBC_SETUP_WAIT_LSB 2
`define CBC_SETUP_WAIT_MSB 4
`define CBC_SETUP_PTR_LO_LSB 5
`define CBC_SETUP_PTR_LO_MSB 7
`define CBC_SETUP_PTR_HI_BIT 8
`define CBC_SETUP_GO_BIT 9

// command register bits
`define CBC_CMD_ENABLE_BIT 0
`define CBC_CMD_INHIBIT_BIT 1

// interrupt status bits
`define CBC_IRQ_EOB_BIT 0
`define CBC_IRQ_WRAP_BIT 1

// state register fields
`define CBC_STATE_CELLS_LSB 0
`define CBC_STATE_CELLS_MSB 11
`define CBC_STATE_PTR_LSB 12
`define CBC_STATE_PTR_MSB 15
`define CBC_STATE_SECS_LSB 16
`define CBC_STATE_SECS_MSB 27

// pattern store
`define CBC_PAT_W 12
`define CBC_PAT_DEPTH 13
`define CBC_PTR_MANUAL 4'h0
`define CBC_PTR_AUTO_FIRST 4'h1
`define CBC_PTR_AUTO_LAST 4'hc

// timing
`define CBC_CLK_HZ 50000000
`define CBC_TICK_PERIOD_S 1
`define CBC_DUR_STEP_S 12'h014
`define CBC_SECS_W 12
`define CBC_TICK_W 26

// bus answers
`define CBC_RESP_OKAY 2'h0
`define CBC_RESP_SLVERR 2'h2

`endif

// *** include/cbc_pkg.sv ***
// types shared by the cell balance block
package cbc_pkg;

    typedef enum logic [1:0] {
        CBC_MODE_OFF,
        CBC_MODE_MANUAL,
        CBC_MODE_TIMED,
        CBC_MODE_AUTO
    } cbc_mode_t;

    typedef enum logic [2:0] {
        CBC_ST_IDLE,
        CBC_ST_RUN,
        CBC_ST_SETTLE,
        CBC_ST_CHECK,
        CBC_ST_ON,
        CBC_ST_WAIT
    } cbc_state_t;

    typedef struct packed {
        cbc_state_t st;
        cbc_mode_t mode;
        logic go;
        logic [2:0] wait_code;
        logic [3:0] ptr;
        logic [6:0] dur_code;
        logic [11:0] secs;
        logic [11:0] cell_on;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cbc_regs_t;

    typedef struct packed {
        logic [12:0][11:0] mem;
        logic [11:0] rd_a;
        logic [11:0] rd_b;
    } cbc_mem_t;

    typedef struct packed {
        logic [25:0] cnt;
        logic tick;
    } cbc_tick_t;

endpackage

// *** rtl/cbc_pattern_mem.sv ***
// thirteen-instance balance pattern store with two registered read ports
`include "cbc_defines.svh"
module cbc_pattern_mem
    import cbc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write port
    input wire logic we_in,
    input wire logic [3:0] waddr_in,
    input wire logic [11:0] wdata_in,
    // read ports
    input wire logic [3:0] raddr_a_in,
    input wire logic [3:0] raddr_b_in,
    output logic [11:0] rdata_a_out,
    output logic [11:0] rdata_b_out
);

    cbc_mem_t r;
    cbc_mem_t next_r;

    // instances past the last read as zero, so auto stepping sees an end
    function automatic logic [11:0] rd(input cbc_mem_t s, input logic [3:0] a);
        if (a <= `CBC_PTR_AUTO_LAST)
        begin
            return s.mem[a];
        end
        return '0;
    endfunction

    always_comb
    begin
        next_r = r;
        if (we_in && waddr_in <= `CBC_PTR_AUTO_LAST)
        begin
            next_r.mem[waddr_in] = wdata_in;
        end
        next_r.rd_a = rd(r, raddr_a_in);
        next_r.rd_b = rd(r, raddr_b_in);
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rdata_a_out = r.rd_a;
    assign rdata_b_out = r.rd_b;

endmodule

// *** rtl/cbc_sec_tick.sv ***
// restartable one-second tick generator
`include "cbc_defines.svh"
module cbc_sec_tick
    import cbc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CBC_CLK_HZ * `CBC_TICK_PERIOD_S
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic restart_in,
    output logic tick_out
);

    localparam logic [25:0] LAST = 26'(TICK_CYCLES - 1);

    cbc_tick_t r;
    cbc_tick_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (restart_in)
        begin
            next_r.cnt = '0;
        end
        else if (r.cnt >= LAST)
        begin
            next_r.cnt = '0;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt + 26'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign tick_out = r.tick;

endmodule

// *** rtl/cbc_top.sv ***
// cell balance control: register bank, balance sequencer and AXI4-Lite slave
//
// Summary of operation
// - Twelve balance outputs, each driven on its own from register settings.
// - Setup: wait code 4..2, mode 1..0, pointer 7..5 plus 8, enable 9.
// - Auto wait between operations: 0,1,2,4,8,16,32,64 seconds by wait code.
// - Mode field: 00 off, 01 manual, 10 timed, 11 auto.
// - Balancing starts when enable becomes 1 with other fields set up.
// - Enable set by setup write or by a balance enable command.
// - Manual mode drives outputs straight from pattern, no timing.
// - Timed mode switches all outputs off when duration elapses.
// - Auto mode removes charge over several on/wait cycles.
// - Pattern bit 0 drives cell 1 up to bit 11 for cell 12.
// - Thirteen pattern instances; host reaches only the pointed-to one.
// - Instance 0 for manual and timed; instances 1 to 12 for auto.
// - Auto mode advances pointer each cycle through instances 1 to 12.
// - Auto mode finding an all-zero instance returns to instance 1.
// - Timed expiry sets end-of-balance flag and clears enable.
// - Clearing enable stops balancing and resets timer; restart uses full time.
// - Duration code counts 20 second steps; zero disables the timer.
`include "cbc_defines.svh"
module cbc_top
    import cbc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CBC_CLK_HZ * `CBC_TICK_PERIOD_S
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // axi4-lite write address
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    // axi4-lite write data
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // axi4-lite write response
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // axi4-lite read address
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    // axi4-lite read data
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // balance transistor drives, bit 0 is cell 1
    output logic [11:0] cell_balance_on_out,
    // interrupt
    output logic irq_out
);

    cbc_regs_t r;
    cbc_regs_t next_r;

    logic [11:0] host_pat;
    logic [11:0] run_pat;
    logic [3:0] run_addr;
    logic mem_we;
    logic [11:0] mem_wdata;
    logic tick;
    logic tick_restart;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        return addr[7:2] == idx;
    endfunction

    function automatic logic [11:0] wait_seconds(input logic [2:0] code);
        if (code == 3'h0)
        begin
            return '0;
        end
        return 12'h1 << (code - 3'h1);
    endfunction

    function automatic logic [11:0] dur_seconds(input logic [6:0] code);
        return 12'({5'h0, code} * `CBC_DUR_STEP_S);
    endfunction

    function automatic logic [3:0] step_ptr(input logic [3:0] p);
        if (p >= `CBC_PTR_AUTO_LAST)
        begin
            return `CBC_PTR_AUTO_FIRST;
        end
        return p + 4'h1;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v;
    endfunction

    function automatic logic [31:0] setup_word(input cbc_regs_t s);
        logic [31:0] v;
        v = '0;
        v[`CBC_SETUP_MODE_MSB:`CBC_SETUP_MODE_LSB] = s.mode;
        v[`CBC_SETUP_WAIT_MSB:`CBC_SETUP_WAIT_LSB] = s.wait_code;
        v[`CBC_SETUP_PTR_LO_MSB:`CBC_SETUP_PTR_LO_LSB] = s.ptr[2:0];
        v[`CBC_SETUP_PTR_HI_BIT] = s.ptr[3];
        v[`CBC_SETUP_GO_BIT] = s.go;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pattern store and second tick

    // manual and timed run from instance 0, auto from the pointer
    assign run_addr = (r.mode == CBC_MODE_AUTO) ? r.ptr : `CBC_PTR_MANUAL;

    cbc_pattern_mem u_mem (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .we_in(mem_we),
        .waddr_in(r.ptr),
        .wdata_in(mem_wdata),
        .raddr_a_in(r.ptr),
        .raddr_b_in(run_addr),
        .rdata_a_out(host_pat),
        .rdata_b_out(run_pat)
    );

    cbc_sec_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(tick_restart),
        .tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [1:0] ev;
        logic [31:0] wv;
        logic [7:0] a;
        next_r = r;
        ev = '0;
        wv = '0;
        a = '0;
        mem_we = 1'b0;
        mem_wdata = '0;
        tick_restart = 1'b0;

        // balance sequencer
        if (!r.go || r.mode == CBC_MODE_OFF)
        begin
            // disabling drops outputs and forgets the timer
            next_r.st = CBC_ST_IDLE;
            next_r.cell_on = '0;
            next_r.secs = '0;
        end
        else
        begin
            case (r.st)
                CBC_ST_IDLE:
                begin
                    // a fresh start always loads the full duration
                    if (r.mode == CBC_MODE_AUTO)
                    begin
                        next_r.ptr = `CBC_PTR_AUTO_FIRST;
                        next_r.st = CBC_ST_SETTLE;
                    end
                    else
                    begin
                        next_r.secs = dur_seconds(r.dur_code);
                        tick_restart = 1'b1;
                        next_r.st = CBC_ST_RUN;
                    end
                end
                CBC_ST_RUN:
                begin
                    next_r.cell_on = run_pat;
                    if (r.mode == CBC_MODE_AUTO)
                    begin
                        next_r.st = CBC_ST_IDLE;
                    end
                    else if (r.mode == CBC_MODE_TIMED && r.dur_code != '0 && tick)
                    begin
                        if (r.secs <= 12'h1)
                        begin
                            next_r.cell_on = '0;
                            next_r.go = 1'b0;
                            ev[`CBC_IRQ_EOB_BIT] = 1'b1;
                            next_r.st = CBC_ST_IDLE;
                        end
                        else
                        begin
                            next_r.secs = r.secs - 12'h1;
                        end
                    end
                end
                CBC_ST_SETTLE:
                begin
                    // one cycle for the pattern read to follow the pointer
                    next_r.cell_on = '0;
                    next_r.st = (r.mode == CBC_MODE_AUTO) ? CBC_ST_CHECK : CBC_ST_IDLE;
                end
                CBC_ST_CHECK:
                begin
                    if (r.mode != CBC_MODE_AUTO)
                    begin
                        next_r.st = CBC_ST_IDLE;
                    end
                    else if (run_pat == '0 && r.ptr != `CBC_PTR_AUTO_FIRST)
                    begin
                        next_r.ptr = `CBC_PTR_AUTO_FIRST;
                        ev[`CBC_IRQ_WRAP_BIT] = 1'b1;
                        next_r.st = CBC_ST_SETTLE;
                    end
                    else
                    begin
                        next_r.cell_on = run_pat;
                        next_r.secs = dur_seconds(r.dur_code);
                        tick_restart = 1'b1;
                        next_r.st = CBC_ST_ON;
                    end
                end
                CBC_ST_ON:
                begin
                    // a zero duration holds the current pattern indefinitely
                    if (r.mode != CBC_MODE_AUTO)
                    begin
                        next_r.st = CBC_ST_IDLE;
                    end
                    else if (r.dur_code != '0 && tick && r.secs <= 12'h1)
                    begin
                        next_r.cell_on = '0;
                        if (r.wait_code == '0)
                        begin
                            next_r.ptr = step_ptr(r.ptr);
                            next_r.st = CBC_ST_SETTLE;
                        end
                        else
                        begin
                            next_r.secs = wait_seconds(r.wait_code);
                            tick_restart = 1'b1;
                            next_r.st = CBC_ST_WAIT;
                        end
                    end
                    else if (r.dur_code != '0 && tick)
                    begin
                        next_r.secs = r.secs - 12'h1;
                    end
                end
                CBC_ST_WAIT:
                begin
                    next_r.cell_on = '0;
                    if (r.mode != CBC_MODE_AUTO)
                    begin
                        next_r.st = CBC_ST_IDLE;
                    end
                    else if (tick && r.secs <= 12'h1)
                    begin
                        next_r.ptr = step_ptr(r.ptr);
                        next_r.st = CBC_ST_SETTLE;
                    end
                    else if (tick)
                    begin
                        next_r.secs = r.secs - 12'h1;
                    end
                end
                default:
                begin
                    next_r.st = CBC_ST_IDLE;
                end
            endcase
        end

        // axi write channels, taken in either order
        if (s_axi_awvalid_in && !r.aw_got && !r.bvalid)
        begin
            next_r.aw_got = 1'b1;
            next_r.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !r.w_got && !r.bvalid)
        begin
            next_r.w_got = 1'b1;
            next_r.w_data = s_axi_wdata_in;
            next_r.w_strb = s_axi_wstrb_in;
        end
        if (r.bvalid && s_axi_bready_in)
        begin
            next_r.bvalid = 1'b0;
        end

        // host writes come after the sequencer so they take precedence
        if (r.aw_got && r.w_got && !r.bvalid)
        begin
            a = r.aw_addr;
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `CBC_RESP_OKAY;
            if (hit(a, `CBC_IDX_SETUP))
            begin
                wv = merge(setup_word(r), r.w_data, r.w_strb);
                next_r.mode = cbc_mode_t'(wv[`CBC_SETUP_MODE_MSB:`CBC_SETUP_MODE_LSB]);
                next_r.wait_code = wv[`CBC_SETUP_WAIT_MSB:`CBC_SETUP_WAIT_LSB];
                next_r.ptr = {wv[`CBC_SETUP_PTR_HI_BIT], wv[`CBC_SETUP_PTR_LO_MSB:`CBC_SETUP_PTR_LO_LSB]};
                next_r.go = wv[`CBC_SETUP_GO_BIT];
            end
            else if (hit(a, `CBC_IDX_PATTERN))
            begin
                wv = merge({20'h0, host_pat}, r.w_data, r.w_strb);
                mem_we = 1'b1;
                mem_wdata = wv[11:0];
            end
            else if (hit(a, `CBC_IDX_DURATION))
            begin
                wv = merge({25'h0, r.dur_code}, r.w_data, r.w_strb);
                next_r.dur_code = wv[6:0];
            end
            else if (hit(a, `CBC_IDX_COMMAND))
            begin
                if (r.w_strb[0] && r.w_data[`CBC_CMD_INHIBIT_BIT])
                begin
                    next_r.go = 1'b0;
                end
                else if (r.w_strb[0] && r.w_data[`CBC_CMD_ENABLE_BIT])
                begin
                    next_r.go = 1'b1;
                end
            end
            else if (hit(a, `CBC_IDX_IRQ_MASK))
            begin
                wv = merge({30'h0, r.irq_mask}, r.w_data, r.w_strb);
                next_r.irq_mask = wv[1:0];
            end
            else if (!hit(a, `CBC_IDX_IRQ_STATUS) && !hit(a, `CBC_IDX_STATE))
            begin
                next_r.bresp = `CBC_RESP_SLVERR;
            end
        end

        // axi read, answered one cycle after the address is taken
        if (r.rvalid && s_axi_rready_in)
        begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && !r.rvalid)
        begin
            a = s_axi_araddr_in;
            next_r.rvalid = 1'b1;
            next_r.rresp = `CBC_RESP_OKAY;
            next_r.rdata = '0;
            if (hit(a, `CBC_IDX_SETUP))
            begin
                next_r.rdata = setup_word(r);
            end
            else if (hit(a, `CBC_IDX_PATTERN))
            begin
                next_r.rdata = {20'h0, host_pat};
            end
            else if (hit(a, `CBC_IDX_DURATION))
            begin
                next_r.rdata = {25'h0, r.dur_code};
            end
            else if (hit(a, `CBC_IDX_IRQ_STATUS))
            begin
                next_r.rdata = {30'h0, r.irq_stat};
                next_r.irq_stat = '0;
            end
            else if (hit(a, `CBC_IDX_IRQ_MASK))
            begin
                next_r.rdata = {30'h0, r.irq_mask};
            end
            else if (hit(a, `CBC_IDX_STATE))
            begin
                next_r.rdata[`CBC_STATE_CELLS_MSB:`CBC_STATE_CELLS_LSB] = r.cell_on;
                next_r.rdata[`CBC_STATE_PTR_MSB:`CBC_STATE_PTR_LSB] = r.ptr;
                next_r.rdata[`CBC_STATE_SECS_MSB:`CBC_STATE_SECS_LSB] = r.secs;
            end
            else if (!hit(a, `CBC_IDX_COMMAND))
            begin
                next_r.rresp = `CBC_RESP_SLVERR;
            end
        end

        // an event in the same cycle as a clearing read is kept
        next_r.irq_stat = next_r.irq_stat | ev;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready_out = !r.aw_got && !r.bvalid;
    assign s_axi_wready_out = !r.w_got && !r.bvalid;
    assign s_axi_bvalid_out = r.bvalid;
    assign s_axi_bresp_out = r.bresp;
    assign s_axi_arready_out = !r.rvalid;
    assign s_axi_rvalid_out = r.rvalid;
    assign s_axi_rdata_out = r.rdata;
    assign s_axi_rresp_out = r.rresp;
    assign cell_balance_on_out = r.cell_on;
    assign irq_out = |(r.irq_stat & r.irq_mask);

endmodule

// *** dv/cbc_top_assertions.sv ***
// bus handshake checks on the cell balance block ports
module cbc_chk
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write side
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [1:0] s_axi_bresp_out,
    // read side
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_B_STANDS: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
    AST_B_FREE: assert property (s_axi_bvalid_out && s_axi_bready_in
        |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out) else $error("write not freed");
    AST_W_BLOCK: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken during answer");
    AST_R_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    AST_R_STANDS: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data moved");
    AST_R_RESP: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rresp_out))
        else $error("read resp moved");
    AST_R_FREE: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("read not freed");
    AST_AR_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken during answer");
endmodule
bind cbc_top cbc_chk u_chk (.*);

// *** dv/cbc_host.sv ***
// bus master model standing in for the host controller
module cbc_host
(
    input wire logic clk_in,
    // write channels
    output logic aw_v_out,
    input wire logic aw_r_in,
    output logic [7:0] aw_a_out,
    output logic w_v_out,
    input wire logic w_r_in,
    output logic [31:0] w_d_out,
    input wire logic b_v_in,
    output logic b_r_out,
    input wire logic [1:0] b_resp_in,
    // read channels
    output logic ar_v_out,
    input wire logic ar_r_in,
    output logic [7:0] ar_a_out,
    input wire logic r_v_in,
    output logic r_r_out,
    input wire logic [31:0] r_d_in,
    input wire logic [1:0] r_resp_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        aw_v_out = 1'b0;
        aw_a_out = 8'h00;
        w_v_out = 1'b0;
        w_d_out = 32'h0;
        b_r_out = 1'b0;
        ar_v_out = 1'b0;
        ar_a_out = 8'h00;
        r_r_out = 1'b0;
    end
    // ready rises late on purpose so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge clk_in);
        aw_v_out <= 1'b1;
        aw_a_out <= a;
        w_v_out <= 1'b1;
        w_d_out <= d;
        do
        begin
            @(posedge clk_in);
            if (aw_r_in)
                aw_v_out <= 1'b0;
            if (w_r_in)
                w_v_out <= 1'b0;
        end
        while (!b_v_in);
        b_r_out <= 1'b1;
        @(posedge clk_in);
        b_r_out <= 1'b0;
        rs = b_resp_in;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk_in);
        ar_v_out <= 1'b1;
        ar_a_out <= a;
        do
            @(posedge clk_in);
        while (!ar_r_in);
        ar_v_out <= 1'b0;
        do
            @(posedge clk_in);
        while (!r_v_in);
        r_r_out <= 1'b1;
        @(posedge clk_in);
        r_r_out <= 1'b0;
        d = r_d_in;
        rs = r_resp_in;
    endtask
endmodule

// *** dv/cbc_top_tb.sv ***
// self-checking bench for the cell balance block
module cbc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} cbc_row_t;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, irq_out;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
    logic [11:0] cell_balance_on_out;
    int err_total = 0;
    int n_compared = 0;
    int k;
    cbc_row_t rows[8] = '{
        '{8'h4c, 32'hffff_fc00, 32'h0, 2'h0},
        '{8'h4c, 32'h0000_01fc, 32'h1fc, 2'h0},
        '{8'h50, 32'h0000_0fff, 32'h0, 2'h0},
        '{8'h80, 32'h0000_00ff, 32'h7f, 2'h0},
        '{8'h8c, 32'h0000_000f, 32'h3, 2'h0},
        '{8'h84, 32'h0000_0002, 32'h0, 2'h0},
        '{8'h90, 32'h0000_0000, 32'hf000, 2'h0},
        '{8'h40, 32'h0000_0001, 32'h0, 2'h2}};
    cbc_top #(.TICK_CYCLES(4)) dut (.*);
    cbc_host h (
        .clk_in(clk_in),
        .aw_v_out(s_axi_awvalid_in),
        .aw_r_in(s_axi_awready_out),
        .aw_a_out(s_axi_awaddr_in),
        .w_v_out(s_axi_wvalid_in),
        .w_r_in(s_axi_wready_out),
        .w_d_out(s_axi_wdata_in),
        .b_v_in(s_axi_bvalid_out),
        .b_r_out(s_axi_bready_in),
        .b_resp_in(s_axi_bresp_out),
        .ar_v_out(s_axi_arvalid_in),
        .ar_r_in(s_axi_arready_out),
        .ar_a_out(s_axi_araddr_in),
        .r_v_in(s_axi_rvalid_out),
        .r_r_out(s_axi_rready_in),
        .r_d_in(s_axi_rdata_out),
        .r_resp_in(s_axi_rresp_out)
    );
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_out(input logic [11:0] e);
        for (k = 0; k < 300 && cell_balance_on_out !== e; k++)
            @(posedge clk_in);
        chk(32'(cell_balance_on_out), 32'(e));
    endtask
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
        forever #10 clk_in = ~clk_in;
    initial
    begin
        #100us;
        err_total++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        chk(32'({cell_balance_on_out, irq_out}), 32'h0);
        h.rd(8'h4c, rv, rs);
        chk(rv, 32'h0);
        foreach (rows[i])
        begin
            h.wr(rows[i].a, rows[i].d, rs);
            chk(32'(rs), 32'(rows[i].r));
            h.rd(rows[i].a, rv, rs);
            chk(rv, rows[i].q);
            chk(32'(rs), 32'(rows[i].r));
        end
        // host sets every field before enabling
        h.wr(8'h4c, 32'h001, rs);
        h.wr(8'h50, 32'h801, rs);
        h.wr(8'h4c, 32'h201, rs);
        wait_out(12'h801);
        h.wr(8'h84, 32'h3, rs);
        wait_out(12'h000);
        h.wr(8'h84, 32'h1, rs);
        wait_out(12'h801);
        h.wr(8'h4c, 32'h200, rs);
        wait_out(12'h000);
        // timed run, one duration step of twenty ticks
        h.wr(8'h80, 32'h1, rs);
        h.wr(8'h8c, 32'h1, rs);
        h.rd(8'h88, rv, rs);
        h.wr(8'h4c, 32'h202, rs);
        wait_out(12'h801);
        wait_out(12'h000);
        chk(32'(k inside {[76:82]}), 32'h1);
        chk(32'(irq_out), 32'h1);
        h.rd(8'h4c, rv, rs);
        chk(rv, 32'h002);
        h.rd(8'h88, rv, rs);
        chk(rv, 32'h1);
        chk(32'(irq_out), 32'h0);
        // auto run over two patterns then an empty one, one second wait
        h.wr(8'h4c, 32'h020, rs);
        h.wr(8'h50, 32'h555, rs);
        h.wr(8'h4c, 32'h040, rs);
        h.wr(8'h50, 32'haaa, rs);
        h.wr(8'h8c, 32'h2, rs);
        h.wr(8'h4c, 32'h227, rs);
        wait_out(12'h555);
        wait_out(12'h000);
        wait_out(12'haaa);
        chk(32'(k inside {[6:8]}), 32'h1);
        wait_out(12'h555);
        chk(32'(irq_out), 32'h1);
        end_of_test();
    end
endmodule
